// ===== rtl/configurable_io_ports.v
`timescale 1ns/100ps
`include "io_port_defs.vh"
module configurable_io_ports #(
  parameter TOOLS = 32,
  parameter CLK_PER_MS = `CLK_FREQ_HZ / `MS_PER_SEC
) (
  input wire aclk,
  input wire aresetn,
  input wire [7:0] awaddr,
  input wire awvalid,
  output reg awready,
  input wire [31:0] wdata,
  input wire [3:0] wstrb,
  input wire wvalid,
  output reg wready,
  output reg [1:0] bresp,
  output reg bvalid,
  input wire bready,
  input wire [7:0] araddr,
  input wire arvalid,
  output reg arready,
  output reg [31:0] rdata,
  output reg [1:0] rresp,
  output reg rvalid,
  input wire rready,
  input wire [7:0] io_in,
  output reg [7:0] io_out,
  output reg [7:0] io_oe_n,
  input wire check_busy,
  input wire check_done,
  input wire [TOOLS-1:0] tool_result,
  input wire [TOOLS-1:0] tool_used,
  input wire exposure,
  input wire prog_loading,
  input wire device_fault,
  output reg acq_start,
  output reg prog_load,
  output reg [5:0] prog_sel,
  output reg gate_open
);
  localparam NP = `NUM_PORTS;
  localparam CLK_LAST = CLK_PER_MS - 1;
  localparam [15:0] PS_LAST = CLK_LAST[15:0];

  // ****************************************
  // Millisecond timebase
  // ****************************************
  reg [15:0] ps;
  reg tick;
  always @(posedge aclk) begin
    if (!aresetn) begin
      ps <= 16'h0000;
      tick <= 1'b0;
    end else begin
      tick <= (ps == PS_LAST);
      ps <= (ps == PS_LAST) ? 16'h0000 : ps + 16'h0001;
    end
  end

  // ****************************************
  // Configuration store
  // ****************************************
  reg [31:0] cfg [0:NP-1];
  reg [31:0] tim [0:NP-1];
  reg couple;
  reg fault_latched;
  reg [15:0] lost_cnt;

  wire [1:0] mode [0:NP-1];
  wire [3:0] func [0:NP-1];
  wire [3:0] in_fn [0:NP-1];
  wire [3:0] out_fn [0:NP-1];
  wire [2:0] sel_idx [0:NP-1];
  wire [4:0] tool_idx [0:NP-1];
  wire inv [0:NP-1];
  wire [NP-1:0] filt;
  wire [NP-1:0] chan_out;

  reg trig_acc;
  reg ready_q;
  reg pass;

  genvar g;
  generate
    for (g = 0; g < NP; g = g + 1) begin : port
      wire is_res;
      wire is_rdy;
      wire is_prg;
      wire static_mode;
      reg rdy_arm;
      assign mode[g] = cfg[g][`CFG_MODE_LSB +: 2];
      assign func[g] = cfg[g][`CFG_FUNC_LSB +: 4];
      // Functions that do not match the mode behave as passive
      assign in_fn[g] = (mode[g] == `MODE_INPUT && !func[g][3]) ? func[g] : `FN_NONE;
      assign out_fn[g] = (mode[g] == `MODE_OUTPUT && func[g][3]) ? func[g] : `FN_NONE;
      assign sel_idx[g] = cfg[g][`CFG_SEL_LSB +: 3];
      assign tool_idx[g] = cfg[g][`CFG_TOOL_LSB +: 5];
      assign inv[g] = cfg[g][`CFG_INV_BIT];
      assign is_res = (out_fn[g] == `FN_RESULT);
      assign is_rdy = (out_fn[g] == `FN_READY);
      assign is_prg = (out_fn[g] == `FN_PROG);
      assign static_mode = (tim[g][`TIM_PULSE_LSB +: 16] == 16'h0000);
      // A port switched to ready while already ready still needs its own rise
      always @(posedge aclk) begin
        if (!aresetn) begin
          rdy_arm <= 1'b0;
        end else begin
          rdy_arm <= is_rdy & ready_q;
        end
      end
      port_timing u_tim (
        .aclk(aclk),
        .aresetn(aresetn),
        .tick(tick),
        .pin(io_in[g] & (in_fn[g] != `FN_NONE)),
        .deb(cfg[g][`CFG_DEB_LSB +: 10]),
        .delay((is_res | is_rdy | is_prg) ? tim[g][`TIM_DLY_LSB +: 16] : 16'h0000),
        .pulse(is_rdy ? 16'h0000 : tim[g][`TIM_PULSE_LSB +: 16]),
        .set(((is_res | is_prg) & check_done) | (is_rdy & ready_q & ~rdy_arm)),
        .val(is_rdy | (is_res & pass) | (is_prg & tool_result[tool_idx[g]])),
        .clr(((is_res | is_prg) & static_mode & trig_acc) | (is_rdy & ~ready_q)),
        .filt(filt[g]),
        .out(chan_out[g])
      );
    end
  endgenerate

  // ****************************************
  // Input function decode
  // ****************************************
  reg trig_lvl;
  reg gss_lvl;
  reg gon_lvl;
  reg goff_lvl;
  reg pchg_lvl;
  reg [7:0] psel_vec;
  reg [15:0] trig_dly;
  integer i;
  always @* begin
    trig_lvl = 1'b0;
    gss_lvl = 1'b0;
    gon_lvl = 1'b0;
    goff_lvl = 1'b0;
    pchg_lvl = 1'b0;
    psel_vec = 8'h00;
    trig_dly = 16'h0000;
    pass = &(tool_result | ~tool_used);
    for (i = 0; i < NP; i = i + 1) begin
      case (in_fn[i])
        `FN_TRIG: begin
          trig_lvl = filt[i] ^ inv[i];
          trig_dly = tim[i][`TIM_DLY_LSB +: 16];
        end
        `FN_GATE_SS: gss_lvl = filt[i];
        `FN_GATE_ON: gon_lvl = filt[i];
        `FN_GATE_OFF: goff_lvl = filt[i];
        `FN_PSEL: psel_vec[sel_idx[i]] = filt[i];
        `FN_PCHG: pchg_lvl = filt[i];
        default: begin
        end
      endcase
    end
  end

  // ****************************************
  // Trigger, gate and program change
  // ****************************************
  reg trig_prev;
  reg gss_prev;
  reg gon_prev;
  reg goff_prev;
  reg pchg_prev;
  reg tdly_active;
  reg [15:0] tdly_cnt;
  reg load_pend;
  reg [5:0] sel_prev;
  reg [5:0] sel_stable;
  reg [2:0] settle_cnt;
  reg lost_clr;
  reg fault_clr;
  wire trig_rise = trig_lvl & ~trig_prev;
  // A pending delay or program load also blocks triggers
  wire ready_int = ~check_busy & ~prog_loading & ~tdly_active & ~load_pend & ~acq_start;

  always @(posedge aclk) begin
    if (!aresetn) begin
      trig_prev <= 1'b0;
      gss_prev <= 1'b0;
      gon_prev <= 1'b0;
      goff_prev <= 1'b0;
      pchg_prev <= 1'b0;
      tdly_active <= 1'b0;
      tdly_cnt <= 16'h0000;
      acq_start <= 1'b0;
      trig_acc <= 1'b0;
      lost_cnt <= 16'h0000;
      gate_open <= 1'b0;
      load_pend <= 1'b0;
      prog_load <= 1'b0;
      prog_sel <= 6'h00;
      sel_prev <= 6'h00;
      sel_stable <= 6'h00;
      settle_cnt <= 3'h0;
      ready_q <= 1'b0;
      fault_latched <= 1'b0;
    end else begin
      trig_prev <= trig_lvl;
      gss_prev <= gss_lvl;
      gon_prev <= gon_lvl;
      goff_prev <= goff_lvl;
      pchg_prev <= pchg_lvl;
      ready_q <= ready_int;
      acq_start <= 1'b0;
      trig_acc <= 1'b0;
      prog_load <= 1'b0;
      if (trig_rise && ready_int) begin
        trig_acc <= 1'b1;
        if (trig_dly == 16'h0000) begin
          acq_start <= 1'b1;
        end else begin
          tdly_active <= 1'b1;
          tdly_cnt <= 16'h0000;
        end
      end else if (tdly_active && tick) begin
        if (tdly_cnt + 16'h0001 >= trig_dly) begin
          tdly_active <= 1'b0;
          acq_start <= 1'b1;
        end else begin
          tdly_cnt <= tdly_cnt + 16'h0001;
        end
      end
      // Lost triggers saturate; a clear in the same cycle keeps the new event
      if (trig_rise && !ready_int) begin
        lost_cnt <= lost_clr ? 16'h0001 : lost_cnt + {15'h0000, lost_cnt != 16'hFFFF};
      end else if (lost_clr) begin
        lost_cnt <= 16'h0000;
      end
      if ((gss_lvl && !gss_prev) || (gon_lvl && !gon_prev)) begin
        gate_open <= 1'b1;
      end else if ((!gss_lvl && gss_prev) || (goff_lvl && !goff_prev)) begin
        gate_open <= 1'b0;
      end
      // Selection must sit still 5 ms past its own debounce before use
      if (psel_vec[5:0] != sel_prev) begin
        sel_prev <= psel_vec[5:0];
        settle_cnt <= 3'h0;
      end else if (settle_cnt == `SETTLE_MS) begin
        sel_stable <= sel_prev;
      end else if (tick) begin
        settle_cnt <= settle_cnt + 3'h1;
      end
      if (pchg_lvl && !pchg_prev) begin
        load_pend <= 1'b1;
      end else if (load_pend && !check_busy && !prog_loading) begin
        load_pend <= 1'b0;
        prog_load <= 1'b1;
        prog_sel <= sel_stable;
      end
      fault_latched <= device_fault | fault_latched;
      if (fault_clr && !device_fault) begin
        fault_latched <= 1'b0;
      end
    end
  end

  // ****************************************
  // Pin drivers
  // ****************************************
  integer k;
  always @(posedge aclk) begin
    if (!aresetn) begin
      io_out <= 8'h00;
      io_oe_n <= 8'hFF;
    end else begin
      for (k = 0; k < NP; k = k + 1) begin
        io_oe_n[k] <= (out_fn[k] == `FN_NONE);
        case (out_fn[k])
          // Flash stays live even when the process outputs are decoupled
          `FN_FLASH: io_out[k] <= exposure ^ inv[k];
          `FN_ERROR: io_out[k] <= couple & (fault_latched ^ inv[k]);
          `FN_RESULT, `FN_READY, `FN_PROG: io_out[k] <= couple & (chan_out[k] ^ inv[k]);
          default: io_out[k] <= 1'b0;
        endcase
      end
    end
  end

  // ****************************************
  // AXI4-Lite slave
  // ****************************************
  reg aw_held;
  reg w_held;
  reg [7:0] aw_q;
  reg [31:0] wd_q;
  reg [3:0] ws_q;
  wire [7:0] w_rel = aw_q - `PORT_BASE;
  wire w_port_hit = (aw_q >= `PORT_BASE) && (w_rel[7:6] == 2'b00) && (aw_q[1:0] == 2'b00);
  wire [2:0] w_port = w_rel[5:3];
  wire [7:0] r_rel = araddr - `PORT_BASE;
  wire r_port_hit = (araddr >= `PORT_BASE) && (r_rel[7:6] == 2'b00) && (araddr[1:0] == 2'b00);

  function [31:0] merge;
    input [31:0] old;
    input [31:0] nw;
    input [3:0] strb;
    integer b;
    begin
      for (b = 0; b < 4; b = b + 1) begin
        merge[b*8 +: 8] = strb[b] ? nw[b*8 +: 8] : old[b*8 +: 8];
      end
    end
  endfunction

  // Check a new port setting against the other ports
  reg [31:0] nv;
  reg [31:0] ov;
  reg [7:0] used_psel;
  reg used_trig;
  reg used_pchg;
  reg cfg_ok;
  integer j;
  always @* begin
    used_psel = 8'h00;
    used_trig = 1'b0;
    used_pchg = 1'b0;
    ov = cfg[w_port];
    nv = merge(ov, wd_q, ws_q);
    if (nv[`CFG_DEB_LSB +: 10] > `DEB_MAX) begin
      nv[`CFG_DEB_LSB +: 10] = `DEB_MAX;
    end
    for (j = 0; j < NP; j = j + 1) begin
      if (j != w_port && in_fn[j] == `FN_TRIG) used_trig = 1'b1;
      if (j != w_port && in_fn[j] == `FN_PCHG) used_pchg = 1'b1;
      if (j != w_port && in_fn[j] == `FN_PSEL) used_psel[sel_idx[j]] = 1'b1;
    end
    cfg_ok = 1'b1;
    if (nv[`CFG_MODE_LSB +: 2] == `MODE_INPUT) begin
      case (nv[`CFG_FUNC_LSB +: 4])
        `FN_TRIG: if (used_trig) cfg_ok = 1'b0;
        `FN_PCHG: if (used_pchg || !used_psel[0]) cfg_ok = 1'b0;
        `FN_PSEL: begin
          if (nv[`CFG_SEL_LSB +: 3] > `PSEL_MAX || used_psel[nv[`CFG_SEL_LSB +: 3]]) begin
            cfg_ok = 1'b0;
          end
          if (nv[`CFG_SEL_LSB +: 3] != 3'h0 && !used_psel[nv[`CFG_SEL_LSB +: 3] - 3'h1]) begin
            cfg_ok = 1'b0;
          end
        end
        default: begin
        end
      endcase
    end
    if (in_fn[w_port] == `FN_PSEL && (in_fn[w_port] != nv[`CFG_FUNC_LSB +: 4]
        || nv[`CFG_MODE_LSB +: 2] != `MODE_INPUT
        || sel_idx[w_port] != nv[`CFG_SEL_LSB +: 3])) begin
      if (used_psel[sel_idx[w_port] + 3'h1] || (sel_idx[w_port] == 3'h0 && used_pchg)) begin
        cfg_ok = 1'b0;
      end
    end
  end

  integer p;
  always @(posedge aclk) begin
    if (!aresetn) begin
      awready <= 1'b1;
      wready <= 1'b1;
      bvalid <= 1'b0;
      bresp <= `RESP_OKAY;
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_q <= 8'h00;
      wd_q <= 32'h0000_0000;
      ws_q <= 4'h0;
      couple <= `COUPLE_RST;
      fault_clr <= 1'b0;
      lost_clr <= 1'b0;
      for (p = 0; p < NP; p = p + 1) begin
        cfg[p] <= `CFG_RST;
        tim[p] <= `TIM_RST;
      end
    end else begin
      fault_clr <= 1'b0;
      lost_clr <= 1'b0;
      if (awvalid && awready) begin
        aw_q <= awaddr;
        awready <= 1'b0;
        aw_held <= 1'b1;
      end
      if (wvalid && wready) begin
        wd_q <= wdata;
        ws_q <= wstrb;
        wready <= 1'b0;
        w_held <= 1'b1;
      end
      if (aw_held && w_held && !bvalid) begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        bvalid <= 1'b1;
        bresp <= `RESP_OKAY;
        if (aw_q == `CTRL_OFF) begin
          if (ws_q[0]) begin
            couple <= wd_q[`CTRL_COUPLE_BIT];
            fault_clr <= wd_q[`CTRL_FCLR_BIT];
          end
        end else if (aw_q == `LOST_OFF) begin
          lost_clr <= 1'b1;
        end else if (aw_q == `STATUS_OFF) begin
          bresp <= `RESP_OKAY;
        end else if (w_port_hit && !aw_q[2]) begin
          if (cfg_ok) begin
            cfg[w_port] <= nv;
          end else begin
            bresp <= `RESP_SLVERR;
          end
        end else if (w_port_hit) begin
          tim[w_port] <= merge(tim[w_port], wd_q, ws_q);
        end else begin
          bresp <= `RESP_DECERR;
        end
      end
      if (bvalid && bready) begin
        bvalid <= 1'b0;
        awready <= 1'b1;
        wready <= 1'b1;
      end
    end
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      arready <= 1'b1;
      rvalid <= 1'b0;
      rdata <= 32'h0000_0000;
      rresp <= `RESP_OKAY;
    end else if (arvalid && arready) begin
      arready <= 1'b0;
      rvalid <= 1'b1;
      rresp <= `RESP_OKAY;
      rdata <= 32'h0000_0000;
      if (araddr == `CTRL_OFF) begin
        rdata <= {31'h0000_0000, couple};
      end else if (araddr == `STATUS_OFF) begin
        rdata <= {filt, 10'h000, prog_sel, 4'h0, fault_latched, load_pend, gate_open, ready_q};
      end else if (araddr == `LOST_OFF) begin
        rdata <= {16'h0000, lost_cnt};
      end else if (r_port_hit) begin
        rdata <= araddr[2] ? tim[r_rel[5:3]] : cfg[r_rel[5:3]];
      end else begin
        rresp <= `RESP_DECERR;
      end
    end else if (rvalid && rready) begin
      rvalid <= 1'b0;
      arready <= 1'b1;
    end
  end
endmodule

// ===== rtl/io_port_defs.vh
`ifndef IO_PORT_DEFS_VH
`define IO_PORT_DEFS_VH
// ****************************************
// Register offsets
// ****************************************
`define CTRL_OFF 8'h00
`define STATUS_OFF 8'h04
`define LOST_OFF 8'h08
`define PORT_BASE 8'h40
`define NUM_PORTS 8
// ****************************************
// Fields
// ****************************************
`define CFG_MODE_LSB 0
`define CFG_FUNC_LSB 4
`define CFG_INV_BIT 8
`define CFG_SEL_LSB 9
`define CFG_TOOL_LSB 16
`define CFG_DEB_LSB 22
`define TIM_DLY_LSB 0
`define TIM_PULSE_LSB 16
`define CTRL_COUPLE_BIT 0
`define CTRL_FCLR_BIT 1
// ****************************************
// Reset values
// ****************************************
`define CFG_RST 32'h0000_0000
`define TIM_RST 32'h0000_0000
`define COUPLE_RST 1'b1
// ****************************************
// Modes and functions
// ****************************************
`define MODE_PASSIVE 2'h0
`define MODE_INPUT 2'h1
`define MODE_OUTPUT 2'h2
`define FN_NONE 4'h0
`define FN_TRIG 4'h1
`define FN_GATE_SS 4'h2
`define FN_GATE_ON 4'h3
`define FN_GATE_OFF 4'h4
`define FN_PSEL 4'h5
`define FN_PCHG 4'h6
`define FN_RESULT 4'h8
`define FN_READY 4'h9
`define FN_PROG 4'hA
`define FN_FLASH 4'hB
`define FN_ERROR 4'hC
// ****************************************
// Timing and limits
// ****************************************
`define CLK_FREQ_HZ 25000000
`define MS_PER_SEC 1000
`define DEB_MAX 10'h3E8
`define SETTLE_MS 3'h5
`define PSEL_MAX 3'h5
// ****************************************
// Bus answers
// ****************************************
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`define RESP_DECERR 2'h3
`endif

// ===== rtl/port_timing.v
`timescale 1ns/100ps
// ****************************************
// Per-port debounce and output timing
// ****************************************
module port_timing (
  input wire aclk,
  input wire aresetn,
  input wire tick,
  input wire pin,
  input wire [9:0] deb,
  input wire [15:0] delay,
  input wire [15:0] pulse,
  input wire set,
  input wire val,
  input wire clr,
  output reg filt,
  output reg out
);
  localparam [2:0] ST_IDLE = 3'h1;
  localparam [2:0] ST_DLY = 3'h2;
  localparam [2:0] ST_ON = 3'h4;

  reg [9:0] dcnt;
  reg [15:0] tcnt;
  reg [2:0] state;
  reg pend;

  // Glitches spanning fewer than deb ticks never reach filt
  always @(posedge aclk) begin
    if (!aresetn) begin
      dcnt <= 10'h000;
      filt <= 1'b0;
    end else if (pin == filt) begin
      dcnt <= 10'h000;
    end else if (dcnt >= deb) begin
      filt <= pin;
      dcnt <= 10'h000;
    end else if (tick) begin
      dcnt <= dcnt + 10'h001;
    end
  end

  // Pulse of zero keeps the value until clr
  always @(posedge aclk) begin
    if (!aresetn) begin
      tcnt <= 16'h0000;
      state <= ST_IDLE;
      pend <= 1'b0;
      out <= 1'b0;
    end else if (set) begin
      pend <= val;
      tcnt <= 16'h0000;
      if (delay == 16'h0000) begin
        out <= val;
        state <= (val && pulse != 16'h0000) ? ST_ON : ST_IDLE;
      end else begin
        state <= ST_DLY;
      end
    end else if (clr) begin
      out <= 1'b0;
      state <= ST_IDLE;
    end else if (tick) begin
      case (state)
        ST_DLY: begin
          if (tcnt + 16'h0001 >= delay) begin
            out <= pend;
            tcnt <= 16'h0000;
            state <= (pend && pulse != 16'h0000) ? ST_ON : ST_IDLE;
          end else begin
            tcnt <= tcnt + 16'h0001;
          end
        end
        ST_ON: begin
          if (tcnt + 16'h0001 >= pulse) begin
            out <= 1'b0;
            state <= ST_IDLE;
          end else begin
            tcnt <= tcnt + 16'h0001;
          end
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end
endmodule

// ===== testbench/io_ports_monitor.sv
`timescale 1ns/100ps
module io_ports_monitor (
  input wire aclk,
  input wire aresetn,
  input wire check_busy,
  input wire prog_loading,
  input wire acq_start,
  input wire prog_load,
  input wire [7:0] io_out,
  input wire [7:0] io_oe_n
);
  // ********
  // Properties
  // ********
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // Reset ones must see the reset itself, so they keep no disable
  a_oe_reset: assert property (disable iff (1'b0) !aresetn |=> io_oe_n == 8'hFF)
    else $error("port drives after reset");
  a_out_reset: assert property (disable iff (1'b0) !aresetn |=> io_out == 8'h00)
    else $error("pin level after reset");
  a_acq_pulse: assert property (acq_start |=> !acq_start [*2])
    else $error("acquisition start too long");
  a_acq_ready: assert property (acq_start |-> !$past(check_busy))
    else $error("acquisition while busy");
  a_busy_noacq: assert property (check_busy [*2] |-> !acq_start)
    else $error("trigger taken while busy");
  a_load_pulse: assert property (prog_load |=> !prog_load)
    else $error("program load too long");
  a_load_idle: assert property ($rose(prog_load) |-> !$past(check_busy) && !$past(prog_loading))
    else $error("program load during check");
  a_load_noacq: assert property (prog_loading [*2] |-> !acq_start)
    else $error("acquisition while loading");
endmodule

// ===== testbench/machine_model.sv
`timescale 1ns/100ps
module machine_model (
  aclk,
  drv
);
  input wire aclk;
  output reg [7:0] drv;
  // Lines rest low; every change lands just after an edge
  initial drv = 8'h00;
  // Caller sets hold times: trigger past its delay, selection settled before strobe
  task lvl(input integer p, input bit v);
    @(posedge aclk);
    drv[p] <= v;
  endtask
endmodule

// ===== testbench/tb_configurable_digital_io_ports.sv
`timescale 1ns/100ps
module tb_configurable_digital_io_ports;
  reg aclk = 0;
  reg aresetn = 0;
  reg [7:0] awaddr = 0, araddr = 0;
  reg awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  reg [31:0] wdata = 0, tool_result = 0, tool_used = 0, u, v, d;
  reg [3:0] wstrb = 4'hF;
  reg check_busy = 0, check_done = 0, exposure = 0, prog_loading = 0, device_fault = 0;
  reg [1:0] r;
  wire awready, wready, bvalid, arready, rvalid, acq_start, prog_load, gate_open;
  wire [1:0] bresp, rresp;
  wire [31:0] rdata;
  wire [7:0] io_out, io_oe_n, drv, io_in;
  wire [5:0] prog_sel;
  integer errors = 0, n_checks = 0, n_acq = 0, n_load = 0, b, i;
  integer seed = 32'hDA23DA4D;
  always #20 aclk = ~aclk;
  // Pin level: port drives when enabled, else the machine does
  assign io_in = (io_oe_n & drv) | (~io_oe_n & io_out);
  always @(posedge aclk) begin
    n_acq <= n_acq + acq_start;
    n_load <= n_load + prog_load;
  end
  machine_model m (.aclk(aclk), .drv(drv));
  configurable_io_ports #(.CLK_PER_MS(4)) DUT (.aclk, .aresetn, .awaddr, .awvalid, .awready,
    .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready,
    .rdata, .rresp, .rvalid, .rready, .io_in, .io_out, .io_oe_n, .check_busy, .check_done,
    .tool_result, .tool_used, .exposure, .prog_loading, .device_fault, .acq_start,
    .prog_load, .prog_sel, .gate_open);
  // ********
  // Tasks
  // ********
  task chk(input string nm, input [31:0] s, input [31:0] e);
    n_checks = n_checks + 1;
    if (s !== e) begin
      errors = errors + 1;
      $display("ERROR %0s exp %0h seen %0h", nm, e, s);
    end
  endtask
  task wr(input [7:0] a, input [31:0] x);
    awaddr <= a;
    wdata <= x;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid);
    r = bresp;
    bready <= 1'b0;
    @(posedge aclk);
  endtask
  task rd(input [7:0] a);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
    end while (!rvalid);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
    @(posedge aclk);
  endtask
  task cyc(input integer n);
    repeat (n) @(posedge aclk);
  endtask
  task done;
    check_done <= 1'b1;
    @(posedge aclk);
    check_done <= 1'b0;
    cyc(4);
  endtask
  function [31:0] pass_all(input [31:0] us, input [31:0] res);
    pass_all = &(res | ~us);
  endfunction
  task give_verdict;
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // Ten thousand cycles, far beyond the few hundred the sequence needs
  initial begin
    #400000;
    errors = errors + 1;
    give_verdict;
  end
  // ********
  // Sequence
  // ********
  initial begin
    cyc(5);
    aresetn <= 1'b1;
    cyc(2);
    chk("oe", io_oe_n, 8'hFF);
    rd(8'h7C);
    chk("p7", r, 0);
    rd(8'h80);
    chk("p8", r, 3);
    wr(8'h60, 32'h61);
    chk("nosel", r, 2);
    wr(8'h40, 32'h11);
    wr(8'h48, 32'h82);
    wr(8'h50, 32'h92);
    wr(8'h58, 32'h51);
    wr(8'h60, 32'h61);
    chk("chg", r, 0);
    wr(8'h68, 32'h11);
    chk("dup", r, 2);
    wr(8'h68, 32'h451);
    chk("order", r, 2);
    wr(8'h68, 32'hB2);
    wr(8'h70, 32'hC2);
    wr(8'h78, 32'h192);
    cyc(4);
    chk("oe", io_oe_n, 8'h19);
    chk("rdy", io_out[2], 1);
    chk("inv", io_out[7], 0);
    b = n_acq;
    m.lvl(0, 1);
    cyc(6);
    m.lvl(0, 0);
    cyc(6);
    chk("acq", n_acq, b + 1);
    wr(8'h08, 0);
    check_busy <= 1'b1;
    m.lvl(0, 1);
    cyc(6);
    m.lvl(0, 0);
    cyc(6);
    chk("busy", io_out[2], 0);
    check_busy <= 1'b0;
    chk("drop", n_acq, b + 1);
    rd(8'h08);
    chk("lost", d, 1);
    wr(8'h44, 32'h3);
    m.lvl(0, 1);
    cyc(6);
    chk("early", n_acq, b + 1);
    cyc(14);
    m.lvl(0, 0);
    cyc(4);
    chk("late", n_acq, b + 2);
    wr(8'h44, 0);
    // Short glitch then a long pulse against a 3 ms filter
    wr(8'h40, 32'h00C0_0011);
    m.lvl(0, 1);
    cyc(3);
    m.lvl(0, 0);
    cyc(16);
    chk("glitch", n_acq, b + 2);
    m.lvl(0, 1);
    cyc(24);
    m.lvl(0, 0);
    cyc(6);
    chk("long", n_acq, b + 3);
    wr(8'h40, 32'h111);
    cyc(30);
    b = n_acq;
    m.lvl(0, 1);
    cyc(8);
    chk("rise", n_acq, b);
    m.lvl(0, 0);
    cyc(8);
    chk("fall", n_acq, b + 1);
    wr(8'h78, 32'h0003_00A2);
    for (i = 0; i < 6; i = i + 1) begin
      u = $random(seed);
      v = i[0] ? 32'hFFFF_FFFF : $random(seed);
      tool_used <= u;
      tool_result <= v;
      done;
      cyc(8);
      chk("res", io_out[1], pass_all(u, v));
      chk("prog", io_out[7], v[3]);
    end
    chk("hold", io_out[1], 1);
    m.lvl(0, 1);
    m.lvl(0, 0);
    cyc(6);
    chk("clr", io_out[1], 0);
    wr(8'h4C, 32'h0002_0000);
    tool_result <= 32'hFFFF_FFFF;
    done;
    chk("pulse", io_out[1], 1);
    cyc(16);
    chk("end", io_out[1], 0);
    exposure <= 1'b1;
    cyc(4);
    chk("fl", io_out[5], 1);
    exposure <= 1'b0;
    cyc(4);
    chk("fl0", io_out[5], 0);
    device_fault <= 1'b1;
    cyc(4);
    device_fault <= 1'b0;
    cyc(4);
    chk("err", io_out[6], 1);
    wr(8'h68, 32'h21);
    m.lvl(5, 1);
    cyc(4);
    chk("gopen", gate_open, 1);
    m.lvl(5, 0);
    cyc(4);
    chk("gshut", gate_open, 0);
    wr(8'h68, 32'h31);
    wr(8'h70, 32'h41);
    m.lvl(5, 1);
    cyc(4);
    chk("gon", gate_open, 1);
    m.lvl(6, 1);
    cyc(4);
    chk("goff", gate_open, 0);
    // Selection settles well past 5 ms before the strobe
    check_busy <= 1'b1;
    m.lvl(3, 1);
    cyc(30);
    m.lvl(4, 1);
    cyc(8);
    m.lvl(4, 0);
    cyc(12);
    chk("defer", n_load, 0);
    check_busy <= 1'b0;
    cyc(4);
    chk("load", n_load, 1);
    chk("sel", prog_sel, 1);
    prog_loading <= 1'b1;
    cyc(4);
    chk("ldrdy", io_out[2], 0);
    prog_loading <= 1'b0;
    cyc(4);
    give_verdict;
  end
endmodule
bind configurable_io_ports io_ports_monitor mon (.aclk, .aresetn, .check_busy, .prog_loading,
  .acq_start, .prog_load, .io_out, .io_oe_n);
